// ===== logic/astg_pkg.sv
// Constants and types for the acquisition start trigger gate
// Functional notes
// - Gating off: acquisition start generated internally, no outside trigger needed.
// - Gating on: start waiting for acquisition start, ignore frame starts.
// - Acquisition start trigger moves gate to waiting-for-frame-start, frames accepted.
// - Count frame starts; at frame count return to waiting for acquisition start.
// - Frame count accepts 1 to 255; software programs it when gating on.
// - Origin select picks software command, hardware input line 1 or hardware input line 2.
// - Software origin: one trigger per host pulse while target is acquisition start.
// - Line origin: edge select chooses rising or falling edge.
// - After reset the origin select defaults to input line 2.
// - Acquisition start triggers outside waiting-for-acquisition-start are discarded.
// - No frame possible until host has issued a capture arm command.
// - Trigger settings and commands apply only to the selected event target.
package astg_pkg;

  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] FRAME_CNT_MIN = 8'h01;
  localparam logic [CNT_W-1:0] FRAME_CNT_MAX = 8'hFF;
  localparam logic [CNT_W-1:0] FRAME_CNT_RST = 8'h01;

  typedef enum logic [1:0] {
    ASTG_SRC_SOFT = 2'h0,
    ASTG_SRC_LINE1 = 2'h1,
    ASTG_SRC_LINE2 = 2'h2
  } astg_src_t;
  localparam astg_src_t SRC_RST = ASTG_SRC_LINE2;

  typedef enum logic {
    ASTG_TGT_ACQ = 1'b0,
    ASTG_TGT_FRAME = 1'b1
  } astg_tgt_t;

  typedef enum logic [2:0] {
    ASTG_ST_IDLE = 3'b001,
    ASTG_ST_WAIT_ACQ = 3'b010,
    ASTG_ST_WAIT_FRM = 3'b100
  } astg_st_t;

  // Host write of the configuration, applies to the selected target
  typedef struct packed {
    logic wr;
    astg_tgt_t target;
    logic gate_en;
    astg_src_t src;
    logic edge_fall;
    logic [CNT_W-1:0] frame_cnt;
  } astg_cfg_wr_t;

  typedef struct packed {
    logic gate_en;
    astg_src_t src;
    logic edge_fall;
    logic [CNT_W-1:0] frame_cnt;
  } astg_cfg_t;

  typedef struct packed {
    astg_st_t st;
    astg_cfg_t cfg;
    logic [CNT_W-1:0] count;
    logic line1_meta;
    logic line1_sync;
    logic line1_prev;
    logic line2_meta;
    logic line2_sync;
    logic line2_prev;
    logic acq_trig;
    logic frame_ok;
    logic waiting_acq;
    logic waiting_frm;
  } astg_state_t;

endpackage

// ===== logic/astg_gate.sv
// Acquisition start trigger gate: arming, source select, frame counting
`timescale 1ns/1ps
module astg_gate (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire astg_pkg::astg_cfg_wr_t cfg_wr_i,
  input wire logic soft_pulse_i,
  input wire astg_pkg::astg_tgt_t soft_target_i,
  input wire logic arm_cmd_i,
  input wire logic stop_cmd_i,
  input wire logic line1_i,
  input wire logic line2_i,
  input wire logic frame_trig_i,
  output logic acq_trig_o,
  output logic frame_ok_o,
  output logic waiting_acq_o,
  output logic waiting_frm_o,
  output logic [astg_pkg::CNT_W-1:0] frame_seen_o
);

  astg_pkg::astg_state_t state_ff;
  astg_pkg::astg_state_t nxt_state;

  // ==========================================================
  // Next state
  always_comb begin
    logic line_rise;
    logic line_fall;
    logic line_edge;
    logic acq_evt;
    nxt_state = state_ff;
    line_rise = 1'b0;
    line_fall = 1'b0;
    line_edge = 1'b0;
    acq_evt = 1'b0;
    nxt_state.line1_meta = line1_i;
    nxt_state.line1_sync = state_ff.line1_meta;
    nxt_state.line1_prev = state_ff.line1_sync;
    nxt_state.line2_meta = line2_i;
    nxt_state.line2_sync = state_ff.line2_meta;
    nxt_state.line2_prev = state_ff.line2_sync;
    nxt_state.acq_trig = 1'b0;
    nxt_state.frame_ok = 1'b0;
    // Configuration lands only when aimed at acquisition start
    if (cfg_wr_i.wr && cfg_wr_i.target == astg_pkg::ASTG_TGT_ACQ) begin
      nxt_state.cfg.gate_en = cfg_wr_i.gate_en;
      nxt_state.cfg.src = cfg_wr_i.src;
      nxt_state.cfg.edge_fall = cfg_wr_i.edge_fall;
      // Zero is out of range and kept at the minimum
      nxt_state.cfg.frame_cnt = (cfg_wr_i.frame_cnt < astg_pkg::FRAME_CNT_MIN) ?
        astg_pkg::FRAME_CNT_MIN : cfg_wr_i.frame_cnt;
    end
    if (state_ff.cfg.src == astg_pkg::ASTG_SRC_LINE2) begin
      line_rise = state_ff.line2_sync && !state_ff.line2_prev;
      line_fall = !state_ff.line2_sync && state_ff.line2_prev;
    end else begin
      line_rise = state_ff.line1_sync && !state_ff.line1_prev;
      line_fall = !state_ff.line1_sync && state_ff.line1_prev;
    end
    line_edge = state_ff.cfg.edge_fall ? line_fall : line_rise;
    if (state_ff.cfg.src == astg_pkg::ASTG_SRC_SOFT) begin
      acq_evt = soft_pulse_i && soft_target_i == astg_pkg::ASTG_TGT_ACQ;
    end else begin
      acq_evt = line_edge;
    end
    unique case (state_ff.st)
      astg_pkg::ASTG_ST_IDLE: begin
        if (arm_cmd_i) begin
          nxt_state.st = state_ff.cfg.gate_en ? astg_pkg::ASTG_ST_WAIT_ACQ :
            astg_pkg::ASTG_ST_WAIT_FRM;
          nxt_state.count = '0;
          nxt_state.acq_trig = !state_ff.cfg.gate_en;
        end
      end
      astg_pkg::ASTG_ST_WAIT_ACQ: begin
        if (!state_ff.cfg.gate_en) begin
          nxt_state.st = astg_pkg::ASTG_ST_WAIT_FRM;
          nxt_state.acq_trig = 1'b1;
          nxt_state.count = '0;
        end else if (acq_evt) begin
          nxt_state.st = astg_pkg::ASTG_ST_WAIT_FRM;
          nxt_state.acq_trig = 1'b1;
          nxt_state.count = '0;
        end
      end
      astg_pkg::ASTG_ST_WAIT_FRM: begin
        if (frame_trig_i) begin
          nxt_state.frame_ok = 1'b1;
          if (state_ff.cfg.gate_en) begin
            if (state_ff.count + 8'h01 >= state_ff.cfg.frame_cnt) begin
              nxt_state.st = astg_pkg::ASTG_ST_WAIT_ACQ;
              nxt_state.count = '0;
            end else begin
              nxt_state.count = state_ff.count + 8'h01;
            end
          end
        end
      end
      default: begin
        nxt_state.st = astg_pkg::ASTG_ST_IDLE;
      end
    endcase
    if (stop_cmd_i) begin
      nxt_state.st = astg_pkg::ASTG_ST_IDLE;
      nxt_state.count = '0;
      // Stop wins over a start in the same cycle
      nxt_state.acq_trig = 1'b0;
    end
    nxt_state.waiting_acq = nxt_state.st == astg_pkg::ASTG_ST_WAIT_ACQ;
    nxt_state.waiting_frm = nxt_state.st == astg_pkg::ASTG_ST_WAIT_FRM;
  end

  // ==========================================================
  // State register
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff <= '0;
      state_ff.st <= astg_pkg::ASTG_ST_IDLE;
      state_ff.cfg.src <= astg_pkg::SRC_RST;
      state_ff.cfg.frame_cnt <= astg_pkg::FRAME_CNT_RST;
    end else if (clk_en_i) begin
      state_ff <= nxt_state;
    end
  end

  assign acq_trig_o = state_ff.acq_trig;
  assign frame_ok_o = state_ff.frame_ok;
  assign waiting_acq_o = state_ff.waiting_acq;
  assign waiting_frm_o = state_ff.waiting_frm;
  assign frame_seen_o = state_ff.count;

  // ==========================================================
  // Checks
  chk_frames_gated: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (state_ff.frame_ok && $past(clk_en_i)) |-> $past(state_ff.st) == astg_pkg::ASTG_ST_WAIT_FRM)
    else $error("frame accepted outside waiting for frame start");
  chk_idle_no_frame: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (state_ff.st == astg_pkg::ASTG_ST_IDLE && clk_en_i) |=> !state_ff.frame_ok)
    else $error("frame possible before arm");
  chk_acq_leaves_wait: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state_ff.acq_trig && $past(state_ff.st) == astg_pkg::ASTG_ST_WAIT_ACQ
    |-> state_ff.st == astg_pkg::ASTG_ST_WAIT_FRM)
    else $error("acquisition start did not open frame wait");
  chk_count_cleared: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state_ff.acq_trig |-> state_ff.count == '0)
    else $error("frame counter not cleared on arming");
  chk_count_limit: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (state_ff.cfg.gate_en && state_ff.st == astg_pkg::ASTG_ST_WAIT_FRM)
    |-> state_ff.count < state_ff.cfg.frame_cnt)
    else $error("frame count passed frames per arming");
  chk_cnt_range: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state_ff.cfg.frame_cnt >= astg_pkg::FRAME_CNT_MIN)
    else $error("frames per arming out of range");
  chk_gate_off_auto: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (clk_en_i && !stop_cmd_i && !state_ff.cfg.gate_en && !cfg_wr_i.wr &&
     state_ff.st == astg_pkg::ASTG_ST_WAIT_ACQ) |=> state_ff.acq_trig)
    else $error("internal acquisition start missing");
  chk_soft_target: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (clk_en_i && !stop_cmd_i && state_ff.cfg.gate_en &&
     state_ff.cfg.src == astg_pkg::ASTG_SRC_SOFT &&
     state_ff.st == astg_pkg::ASTG_ST_WAIT_ACQ && soft_pulse_i &&
     soft_target_i == astg_pkg::ASTG_TGT_ACQ) |=> state_ff.acq_trig)
    else $error("software acquisition start not applied");
  chk_no_stray_acq: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (clk_en_i && state_ff.st == astg_pkg::ASTG_ST_WAIT_FRM) |=> !state_ff.acq_trig)
    else $error("acquisition start acted on outside wait state");
  chk_src_default: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    $rose(reset_n_i) |-> state_ff.cfg.src == astg_pkg::SRC_RST)
    else $error("source select not at line 2 after reset");
  chk_arm_gate_off: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (clk_en_i && !stop_cmd_i && arm_cmd_i && !state_ff.cfg.gate_en &&
     state_ff.st == astg_pkg::ASTG_ST_IDLE)
    |=> (state_ff.acq_trig && state_ff.st == astg_pkg::ASTG_ST_WAIT_FRM))
    else $error("arm with gating off gave no internal start");
  chk_arm_gate_on: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (clk_en_i && !stop_cmd_i && arm_cmd_i && state_ff.cfg.gate_en &&
     state_ff.st == astg_pkg::ASTG_ST_IDLE)
    |=> (!state_ff.acq_trig && state_ff.st == astg_pkg::ASTG_ST_WAIT_ACQ))
    else $error("arm with gating on did not wait for start");
  chk_wait_no_frame: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (clk_en_i && state_ff.st == astg_pkg::ASTG_ST_WAIT_ACQ) |=> !state_ff.frame_ok)
    else $error("frame accepted while waiting for start");
  chk_frame_taken: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (clk_en_i && frame_trig_i && state_ff.st == astg_pkg::ASTG_ST_WAIT_FRM)
    |=> state_ff.frame_ok)
    else $error("frame start dropped while waiting for frames");
  chk_count_step: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (clk_en_i && !stop_cmd_i && frame_trig_i && state_ff.cfg.gate_en &&
     state_ff.st == astg_pkg::ASTG_ST_WAIT_FRM &&
     state_ff.count + 8'h01 < state_ff.cfg.frame_cnt)
    |=> state_ff.count == $past(state_ff.count) + 8'h01)
    else $error("frame start not counted");
  chk_count_return: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (clk_en_i && !stop_cmd_i && frame_trig_i && state_ff.cfg.gate_en &&
     state_ff.st == astg_pkg::ASTG_ST_WAIT_FRM &&
     state_ff.count + 8'h01 == state_ff.cfg.frame_cnt)
    |=> (state_ff.st == astg_pkg::ASTG_ST_WAIT_ACQ && state_ff.count == '0))
    else $error("last frame did not return to start wait");
  chk_cfg_target: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (clk_en_i && cfg_wr_i.wr && cfg_wr_i.target == astg_pkg::ASTG_TGT_FRAME)
    |=> $stable(state_ff.cfg))
    else $error("frame start setting landed on acquisition start");
  chk_cnt_zero: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (clk_en_i && cfg_wr_i.wr && cfg_wr_i.target == astg_pkg::ASTG_TGT_ACQ &&
     cfg_wr_i.frame_cnt == '0) |=> state_ff.cfg.frame_cnt == astg_pkg::FRAME_CNT_MIN)
    else $error("zero frames per arming not held at minimum");
  chk_soft_other_tgt: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (clk_en_i && !stop_cmd_i && state_ff.cfg.gate_en &&
     state_ff.cfg.src == astg_pkg::ASTG_SRC_SOFT &&
     state_ff.st == astg_pkg::ASTG_ST_WAIT_ACQ && soft_pulse_i &&
     soft_target_i == astg_pkg::ASTG_TGT_FRAME) |=> !state_ff.acq_trig)
    else $error("software command for frame start opened acquisition");
  chk_stop_idle: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (clk_en_i && stop_cmd_i)
    |=> (state_ff.st == astg_pkg::ASTG_ST_IDLE && !state_ff.acq_trig))
    else $error("stop did not return to idle");
  chk_line_edge: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (clk_en_i && !stop_cmd_i && state_ff.cfg.gate_en &&
     state_ff.cfg.src == astg_pkg::ASTG_SRC_LINE1 &&
     state_ff.st == astg_pkg::ASTG_ST_WAIT_ACQ &&
     state_ff.line1_sync != state_ff.line1_prev &&
     state_ff.line1_sync != state_ff.cfg.edge_fall) |=> state_ff.acq_trig)
    else $error("selected line edge not taken as acquisition start");
  chk_frozen: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !clk_en_i |=> $stable(state_ff))
    else $error("state moved while clock enable low");

endmodule

// ===== verif/astg_ext_src.sv
// Model of the external trigger source that drives the two input lines
`timescale 1ns/1ps
module astg_ext_src (
  input wire logic ref_clk_i,
  output logic line1_o,
  output logic line2_o
);
  initial begin
    line1_o = 1'b0;
    line2_o = 1'b0;
  end

  // Change one line just after a falling clock edge
  task automatic drive(input int n, input logic v);
    @(negedge ref_clk_i);
    if (n == 1) begin
      line1_o = v;
    end else begin
      line2_o = v;
    end
  endtask
endmodule

// ===== verif/acquisition_start_trigger_gate_tb.sv
// Self-checking bench for the acquisition start trigger gate
`timescale 1ns/1ps
module acquisition_start_trigger_gate_tb;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic stop_i = 1'b0, arm_i = 1'b0, soft_i = 1'b0, frm_i = 1'b0;
  astg_pkg::astg_cfg_wr_t cfg = '0;
  astg_pkg::astg_tgt_t tgt = astg_pkg::ASTG_TGT_ACQ;
  logic line1, line2, acq, fok, w_acq, w_frm;
  logic en = 1'b1;
  logic [7:0] seen;
  int err_total = 0, num_checks = 0, n_acq = 0, n_frm = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  astg_ext_src astg_ext_src_i (.ref_clk_i(ref_clk_i), .line1_o(line1), .line2_o(line2));
  astg_gate astg_gate_i (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .clk_en_i(en),
    .cfg_wr_i(cfg), .soft_pulse_i(soft_i), .soft_target_i(tgt), .arm_cmd_i(arm_i),
    .stop_cmd_i(stop_i), .line1_i(line1), .line2_i(line2), .frame_trig_i(frm_i),
    .acq_trig_o(acq), .frame_ok_o(fok), .waiting_acq_o(w_acq), .waiting_frm_o(w_frm),
    .frame_seen_o(seen));

  // Count one-cycle output pulses
  always @(negedge ref_clk_i) begin
    if (acq === 1'b1) n_acq++;
    if (fok === 1'b1) n_frm++;
  end

  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  // Pulses {stop, arm, soft, frame} for one cycle
  task automatic go(logic [3:0] v);
    @(negedge ref_clk_i);
    {stop_i, arm_i, soft_i, frm_i} = v;
    @(negedge ref_clk_i);
    {stop_i, arm_i, soft_i, frm_i} = 4'h0;
    #1;
  endtask

  task automatic wcfg(astg_pkg::astg_src_t s, logic f, logic [7:0] c, logic g = 1'b1,
    astg_pkg::astg_tgt_t t = astg_pkg::ASTG_TGT_ACQ);
    @(negedge ref_clk_i);
    cfg = {1'b1, t, g, s, f, c};
    @(negedge ref_clk_i);
    cfg.wr = 1'b0;
  endtask

  // Line level change, then time for synchroniser and edge detect
  task automatic pin(int n, logic v);
    astg_ext_src_i.drive(n, v);
    repeat (6) @(negedge ref_clk_i);
    #1;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #50000;
    err_total++;
    print_verdict();
  end

  initial begin
    repeat (5) @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    go(4'h1);
    chk("frame before arm", 8'h00, n_frm[7:0]);
    go(4'h4);
    chk("internal acq", 8'h01, n_acq[7:0]);
    repeat (3) go(4'h1);
    chk("free frames", 8'h03, n_frm[7:0]);
    $display("test gate_off done");
    wcfg(astg_pkg::ASTG_SRC_SOFT, 1'b0, 8'h02);
    go(4'h8);
    go(4'h4);
    go(4'h1);
    chk("waiting_acq", 8'h01, {7'h00, w_acq});
    chk("frame ignored", 8'h03, n_frm[7:0]);
    tgt = astg_pkg::ASTG_TGT_FRAME;
    go(4'h2);
    chk("soft to frame", 8'h01, n_acq[7:0]);
    tgt = astg_pkg::ASTG_TGT_ACQ;
    go(4'h2);
    chk("soft acq", 8'h02, n_acq[7:0]);
    chk("waiting_frm", 8'h01, {7'h00, w_frm});
    go(4'h2);
    chk("late acq", 8'h02, n_acq[7:0]);
    go(4'h1);
    chk("frame_seen", 8'h01, seen);
    go(4'h1);
    chk("back to wait", 8'h01, {7'h00, w_acq});
    chk("frames", 8'h05, n_frm[7:0]);
    go(4'h2);
    chk("count cleared", 8'h00, seen);
    $display("test soft done");
    wcfg(astg_pkg::ASTG_SRC_LINE1, 1'b1, 8'hFF);
    go(4'h8);
    go(4'h4);
    pin(2, 1'b1);
    pin(2, 1'b0);
    chk("line2 ignored", 8'h03, n_acq[7:0]);
    pin(1, 1'b1);
    chk("rising ignored", 8'h03, n_acq[7:0]);
    pin(1, 1'b0);
    chk("falling edge", 8'h04, n_acq[7:0]);
    repeat (254) go(4'h1);
    chk("frame_seen 254", 8'hFE, seen);
    go(4'h1);
    chk("count 255", 8'h01, {7'h00, w_acq});
    $display("test line done");
    pin(1, 1'b1);
    pin(1, 1'b0);
    chk("new acq start", 8'h05, n_acq[7:0]);
    go(4'h1);
    @(negedge ref_clk_i);
    en = 1'b0;
    go(4'h1);
    chk("frozen frames", 8'h05, n_frm[7:0]);
    chk("frozen count", 8'h01, seen);
    @(negedge ref_clk_i);
    en = 1'b1;
    reset_n_i = 1'b0;
    @(negedge ref_clk_i);
    chk("reset waiting_frm", 8'h00, {7'h00, w_frm});
    chk("reset frame_seen", 8'h00, seen);
    reset_n_i = 1'b1;
    go(4'h4);
    chk("reset gate off", 8'h06, n_acq[7:0]);
    wcfg(astg_pkg::ASTG_SRC_SOFT, 1'b0, 8'h00);
    go(4'h8);
    go(4'h4);
    go(4'h2);
    go(4'h1);
    chk("zero count as one", 8'h01, {7'h00, w_acq});
    wcfg(astg_pkg::ASTG_SRC_SOFT, 1'b0, 8'h05, 1'b1, astg_pkg::ASTG_TGT_FRAME);
    go(4'h2);
    go(4'h1);
    chk("frame target cfg", 8'h01, {7'h00, w_acq});
    wcfg(astg_pkg::ASTG_SRC_SOFT, 1'b0, 8'h01, 1'b0);
    go(4'h1);
    chk("gate off in wait", 8'h09, n_acq[7:0]);
    chk("frames total", 8'h08, n_frm[7:0]);
    $display("test reset done");
    print_verdict();
  end
endmodule
